// *** adc_sequence_status_logic.sv ***
// Sequencer, status flags, test register and APB slave of the converter.
`timescale 1ns/1ns
module adc_sequence_status_logic #(
    parameter int RES_W = 10
) (
    input  wire logic              ref_clk_i,     // 100 MHz clock
    input  wire logic              reset_n_i,     // Async reset, active low
    input  wire logic              psel_i,        // APB select
    input  wire logic              penable_i,     // APB enable
    input  wire logic              pwrite_i,      // APB direction
    input  wire logic [7:0]        paddr_i,       // APB byte address
    input  wire logic [31:0]       pwdata_i,      // APB write data
    output logic      [31:0]       prdata_o,      // APB read data
    output logic                   pready_o,      // APB ready
    output logic                   pslverr_o,     // APB error, unmapped
    input  wire logic              special_mode_i,// Special operating mode
    input  wire logic [7:0]        port_pin_inputs_i, // Analog pin levels
    output logic                   conv_req_o,    // Start one conversion
    output logic      [3:0]        conv_chan_o,   // Channel to convert
    input  wire logic              conv_done_i,   // Core conversion end pulse
    input  wire logic [RES_W-1:0]  conv_result_i, // Core result
    input  wire logic [RES_W-1:0]  approx_bits_i, // Live approximation reg
    output logic                   approx_load_o, // Load approximation reg
    output logic      [RES_W-1:0]  approx_data_o, // Value to load
    output logic      [4:0]        test_ctrl_o,   // Factory test select and mux
    output logic                   power_en_o,    // Converter power enable
    output logic                   irq_o          // Level interrupt
);
    import adc_seq_pkg::*;

    initial
    begin
        // Above ten bits the approximation field would run into the reset and test bits.
        if (RES_W < 1 || RES_W > 10)
            $error("RES_W must be 1..10");
    end

    seq_state_t       state_r, state_nxt;
    start_ctrl_t      start_r, start_nxt;
    test_ctrl_t       test_r, test_nxt;
    logic [2:0]       cnt_r, cnt_nxt;
    logic             seq_flag_r, seq_flag_nxt;
    logic             first_r, first_nxt;
    logic [7:0]       done_r, done_nxt;
    logic [7:0]       qual_r, qual_nxt;
    logic [15:0]      slot_r [8];
    logic [15:0]      slot_nxt [8];
    logic             power_r, power_nxt;
    logic             fast_r, fast_nxt;
    logic [1:0]       ist_r, ist_nxt;
    logic [1:0]       imsk_r, imsk_nxt;
    logic [31:0]      rdata_nxt;
    logic             ready_nxt, err_nxt, irq_nxt;
    logic             req_nxt, ld_nxt;
    logic [3:0]       chan_nxt;

    // A request is taken one cycle before pready, giving exactly one wait state; the
    // registered answer keeps the read multiplexer out of the prdata_o timing path.
    wire logic access = psel_i && penable_i && !pready_o;
    wire logic wr     = access && pwrite_i;
    wire logic rd     = access && !pwrite_i;
    wire logic in_res = paddr_i[7:5] == OFS_RESULT[7:5] && paddr_i[1:0] == 2'b00;
    wire logic [2:0] rslot = paddr_i[4:2];
    wire logic soft_rst = wr && paddr_i == OFS_TEST && special_mode_i && pwdata_i[TEST_SOFT_RST];
    wire logic start_wr = wr && paddr_i == OFS_START;

    // Channel for the conversion in slot n.
    function automatic logic [3:0] chan_of(input start_ctrl_t s, input logic [2:0] n);
        logic [3:0] c;
        c = s.chan_sel;
        if (!s.multi_channel_enable)
            chan_of = c;                                         // RULE3
        else if (s.eight_conv_select)
            chan_of = {c[3], n};                                 // RULE2
        else
            chan_of = {c[3:2], n[1:0]};                          // RULE1
    endfunction

    always_comb
    begin
        state_nxt    = state_r;
        start_nxt    = start_r;
        test_nxt     = test_r;
        cnt_nxt      = cnt_r;
        seq_flag_nxt = seq_flag_r;
        first_nxt    = first_r;
        done_nxt     = done_r;
        qual_nxt     = qual_r;
        slot_nxt     = slot_r;
        power_nxt    = power_r;
        fast_nxt     = fast_r;
        ist_nxt      = ist_r;
        imsk_nxt     = imsk_r;
        rdata_nxt    = 32'h0000_0000;
        ready_nxt    = access;
        err_nxt      = 1'b0;
        req_nxt      = 1'b0;
        ld_nxt       = 1'b0;
        chan_nxt     = conv_chan_o;

        // Sequencer.
        case (state_r)
            ST_IDLE:
            begin
            end
            ST_CONV:
            begin
                req_nxt   = 1'b1;
                chan_nxt  = chan_of(start_r, cnt_r);
                state_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                // Done pulses outside this state are dropped; an aborted conversion whose pulse arrives in this state still fills slot cnt_r.
                if (conv_done_i)
                begin
                    slot_nxt[cnt_r] = 16'(conv_result_i) << (16 - RES_W);  // RULE18
                    done_nxt[cnt_r] = 1'b1;                                // RULE7
                    ist_nxt[IRQ_CONV] = 1'b1;
                    cnt_nxt = cnt_r + 3'h1;                                // RULE6
                    state_nxt = ST_CONV;
                    if (cnt_r == (start_r.eight_conv_select ? 3'h7 : 3'h3)) // RULE16
                    begin
                        cnt_nxt = 3'h0;                                    // RULE19
                        if (first_r)
                        begin
                            seq_flag_nxt = 1'b1;                           // RULE4
                            ist_nxt[IRQ_SEQ] = 1'b1;
                        end
                        first_nxt = 1'b0;
                        if (!start_r.repeat_sequence)                      // RULE17
                            state_nxt = ST_IDLE;
                    end
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        if (!power_r)
            state_nxt = ST_IDLE;

        // Register access.
        if (rd)
        begin
            if (paddr_i == OFS_STATUS)                                     // RULE9
            begin
                rdata_nxt[7:0] = done_r;
                rdata_nxt[STAT_CNT_LSB +: 3] = cnt_r;
                rdata_nxt[STAT_SEQ] = seq_flag_r;
                qual_nxt = done_r;
            end
            else if (paddr_i == OFS_START)
                rdata_nxt[6:0] = start_r;
            else if (paddr_i == OFS_TEST)
            begin
                if (special_mode_i)                                        // RULE10
                begin
                    rdata_nxt[RES_W-1:0] = approx_bits_i;                  // RULE11
                    rdata_nxt[TEST_MUX_OUT] = test_r.test_mux_output;
                    rdata_nxt[TEST_SEL_LSB +: 4] = test_r.factory_test_select;
                end
            end
            else if (paddr_i == OFS_PORT)
                rdata_nxt[7:0] = port_pin_inputs_i;                        // RULE14
            else if (paddr_i == OFS_POWER)
                rdata_nxt[1:0] = {fast_r, power_r};
            else if (paddr_i == OFS_IRQ_ST)
                rdata_nxt[1:0] = ist_r;
            else if (paddr_i == OFS_IRQ_MSK)
                rdata_nxt[1:0] = imsk_r;
            else if (in_res)
            begin
                rdata_nxt[15:0] = slot_r[rslot];
                if (fast_r || qual_r[rslot])                               // RULE8
                begin
                    if (!(conv_done_i && state_r == ST_WAIT && cnt_r == rslot))
                        done_nxt[rslot] = 1'b0;
                    qual_nxt[rslot] = 1'b0;
                end
                // Only a flag that stood before this read is cleared; a sequence ending now stays visible.
                if (fast_r)
                    seq_flag_nxt = seq_flag_nxt && !seq_flag_r;            // RULE5
            end
            else
                err_nxt = 1'b1;
        end
        if (wr)
        begin
            if (paddr_i == OFS_START)
            begin
                start_nxt = start_ctrl_t'(pwdata_i[6:0]);
                cnt_nxt   = 3'h0;                                          // RULE15
                done_nxt  = 8'h00;
                qual_nxt  = 8'h00;
                first_nxt = 1'b1;
                seq_flag_nxt = 1'b0;                                       // RULE5
                state_nxt = power_r ? ST_CONV : ST_IDLE;
            end
            else if (paddr_i == OFS_STATUS)
            begin
                if (special_mode_i)                                        // RULE9
                begin
                    // A conversion ending in the same cycle as a flag write keeps its flag if that flag was clear before: set wins.
                    done_nxt = pwdata_i[7:0] | (done_nxt & ~done_r);
                    seq_flag_nxt = pwdata_i[STAT_SEQ] | (seq_flag_nxt & !seq_flag_r);
                end
            end
            else if (paddr_i == OFS_TEST)
            begin
                if (special_mode_i)                                        // RULE10
                begin
                    ld_nxt = 1'b1;                                         // RULE11
                    test_nxt.test_mux_output = pwdata_i[TEST_MUX_OUT];     // RULE13
                    test_nxt.factory_test_select = pwdata_i[TEST_SEL_LSB +: 4];
                end
            end
            else if (paddr_i == OFS_POWER)
                {fast_nxt, power_nxt} = pwdata_i[1:0];
            else if (paddr_i == OFS_IRQ_ST)
                ist_nxt = ist_nxt & ~pwdata_i[1:0] | (ist_nxt & ~ist_r);
            else if (paddr_i == OFS_IRQ_MSK)
                imsk_nxt = pwdata_i[1:0];
            else if (!(paddr_i == OFS_PORT || in_res))                     // RULE14
                err_nxt = 1'b1;
        end
        irq_nxt = |(ist_nxt & imsk_nxt);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r    <= ST_IDLE;
            start_r    <= '0;
            test_r     <= '0;
            cnt_r      <= 3'h0;
            seq_flag_r <= 1'b0;
            first_r    <= 1'b0;
            done_r     <= 8'h00;
            qual_r     <= 8'h00;
            slot_r     <= '{default: 16'h0000};
            power_r    <= 1'b0;
            fast_r     <= 1'b0;
            ist_r      <= 2'h0;
            imsk_r     <= 2'h0;
            prdata_o   <= 32'h0000_0000;
            pready_o   <= 1'b0;
            pslverr_o  <= 1'b0;
            conv_req_o <= 1'b0;
            conv_chan_o <= 4'h0;
            approx_load_o <= 1'b0;
            approx_data_o <= '0;
            irq_o      <= 1'b0;
        end
        else if (soft_rst)
        begin
            state_r    <= ST_IDLE;                                         // RULE12
            start_r    <= '0;
            test_r     <= '0;
            cnt_r      <= 3'h0;
            seq_flag_r <= 1'b0;
            first_r    <= 1'b0;
            done_r     <= 8'h00;
            qual_r     <= 8'h00;
            slot_r     <= '{default: 16'h0000};
            fast_r     <= 1'b0;
            ist_r      <= 2'h0;
            imsk_r     <= 2'h0;
            prdata_o   <= 32'h0000_0000;
            pready_o   <= 1'b1;
            pslverr_o  <= 1'b0;
            conv_req_o <= 1'b0;
            approx_load_o <= 1'b0;
            irq_o      <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            start_r    <= start_nxt;
            test_r     <= test_nxt;
            cnt_r      <= cnt_nxt;
            seq_flag_r <= seq_flag_nxt;
            first_r    <= first_nxt;
            done_r     <= done_nxt;
            qual_r     <= qual_nxt;
            slot_r     <= slot_nxt;
            power_r    <= power_nxt;
            fast_r     <= fast_nxt;
            ist_r      <= ist_nxt;
            imsk_r     <= imsk_nxt;
            prdata_o   <= rdata_nxt;
            pready_o   <= ready_nxt;
            pslverr_o  <= err_nxt;
            conv_req_o <= req_nxt;
            conv_chan_o <= chan_nxt;
            approx_load_o <= ld_nxt;
            approx_data_o <= pwdata_i[RES_W-1:0];
            irq_o      <= irq_nxt;
        end
    end

    assign test_ctrl_o = test_r;
    assign power_en_o  = power_r;

    a_seq_flag_start: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE5
        (start_wr && !soft_rst) |=> !seq_flag_r) else $error("sequence flag not cleared by start");
    a_start_clears: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE15
        (start_wr && !soft_rst) |=> (done_r == 8'h00 && cnt_r == 3'h0)) else $error("start did not clear");
    a_test_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE10
        (rd && paddr_i == OFS_TEST && !special_mode_i) |=> prdata_o == 32'h0) else $error("test read not zero");
    a_port_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE14
        (rd && paddr_i == OFS_PORT) |=> prdata_o[7:0] == $past(port_pin_inputs_i)) else $error("port read wrong");
    a_done_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE7
        (state_r == ST_WAIT && conv_done_i && !wr && !soft_rst) |=> done_r[$past(cnt_r)]) else $error("done flag not set");
    a_single_chan: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE3
        (state_r == ST_CONV && !start_r.multi_channel_enable && !soft_rst) |=> conv_chan_o == $past(start_r.chan_sel))
        else $error("single channel mismatch");
    a_fast_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE8
        (rd && in_res && fast_r && !conv_done_i && !soft_rst) |=> !done_r[$past(rslot)]) else $error("fast clear failed");
    a_no_repeat_stop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE17
        (state_r == ST_WAIT && conv_done_i && !start_r.repeat_sequence && !wr && !soft_rst
         && cnt_r == (start_r.eight_conv_select ? 3'h7 : 3'h3)) |=> state_r == ST_IDLE) else $error("sequence did not stop");
    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        irq_o == |(ist_r & imsk_r)) else $error("irq level wrong");

    // Properties guarding the bus answer, the flags, the counter and the soft reset.
    a_ready_pulse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        pready_o |=> !pready_o) else $error("pready held for more than one cycle");
    a_seq_once: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE4
        (state_r == ST_WAIT && conv_done_i && !first_r && !seq_flag_r && !wr && !soft_rst)
        |=> !seq_flag_r) else $error("sequence flag set after first sequence");
    a_cnt_wrap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE19
        (state_r == ST_WAIT && conv_done_i && start_r.repeat_sequence && power_r && !wr && !soft_rst
         && cnt_r == (start_r.eight_conv_select ? 3'h7 : 3'h3)) |=> (cnt_r == 3'h0 && state_r == ST_CONV))
        else $error("continuous sequence did not wrap");
    a_normal_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE8
        (rd && in_res && !fast_r && !qual_r[rslot] && done_r[rslot] && !soft_rst) |=> done_r[$past(rslot)])
        else $error("unqualified read cleared a flag");
    a_soft_reset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE12
        soft_rst |=> (state_r == ST_IDLE && done_r == 8'h00 && !seq_flag_r && power_r == $past(power_r)))
        else $error("soft reset incomplete");
endmodule

// *** adc_seq_pkg.sv ***
// Package with register map, field layout and types for the converter sequencing and status logic.
// Overview of operation
// RULE1 - Four-conversion multichannel: top bits pick group
// RULE2 - Eight-conversion multichannel: top bit picks block
// RULE3 - Single channel: all four bits, repeated
// RULE4 - Sequence flag set once, first sequence
// RULE5 - Sequence flag cleared by start or read; the code clears it on a result read only when fast clear is on
// RULE6 - Three-bit counter points at next slot
// RULE7 - One done flag per slot, sticky
// RULE8 - Fast clear: any read clears; else qualified
// RULE9 - Status readable; flag writes special only
// RULE10 - Test register special modes only, else zero
// RULE11 - Approximation field reads and loads register
// RULE12 - Soft reset restores all but power
// RULE13 - Four-bit test select plus mux output bit
// RULE14 - Port register returns pin levels, read-only
// RULE15 - Start write aborts and clears flags
// RULE16 - Length select: four or eight conversions
// RULE17 - Repeat bit: single or continuous sequences
// RULE18 - Result slots read-only, left-justified
// RULE19 - Continuous mode wraps counter, overwrites slots
package adc_seq_pkg;
    localparam logic [7:0] OFS_START   = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_TEST    = 8'h08;
    localparam logic [7:0] OFS_PORT    = 8'h0c;
    localparam logic [7:0] OFS_POWER   = 8'h10;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h18;
    localparam logic [7:0] OFS_RESULT  = 8'h20;
    localparam int START_CH_LSB   = 0;
    localparam int START_MULTI    = 4;
    localparam int START_REPEAT   = 5;
    localparam int START_EIGHT    = 6;
    localparam int POWER_EN       = 0;
    localparam int POWER_FAST     = 1;
    localparam int STAT_CNT_LSB   = 8;
    localparam int STAT_SEQ       = 15;
    localparam int TEST_SOFT_RST  = 10;
    localparam int TEST_MUX_OUT   = 11;
    localparam int TEST_SEL_LSB   = 12;
    localparam int IRQ_SEQ        = 0;
    localparam int IRQ_CONV       = 1;
    localparam logic [3:0] CH_REF_HIGH = 4'hc;

    typedef struct packed {
        logic       eight_conv_select;
        logic       repeat_sequence;
        logic       multi_channel_enable;
        logic [3:0] chan_sel;
    } start_ctrl_t;

    typedef struct packed {
        logic       test_mux_output;
        logic [3:0] factory_test_select;
    } test_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_WAIT = 3'b100
    } seq_state_t;
endpackage

// *** adc_core_model.sv ***
// Behavioural model of the analog multiplexer and comparator core facing the sequencer.
`timescale 1ns/1ns
module adc_core_model #(
    parameter int RES_W = 10
) (
    input  wire logic             clk_i,       // Module clock
    input  wire logic             reset_n_i,   // Async reset, active low
    input  wire logic             req_i,       // Start one conversion
    input  wire logic [3:0]       chan_i,      // Channel to convert
    input  wire logic             slow_i,      // High for long conversions
    input  wire logic             load_i,      // Load approximation register
    input  wire logic [RES_W-1:0] load_data_i, // Value to load
    output logic                  done_o,      // Conversion end pulse
    output logic      [RES_W-1:0] result_o,    // Result, valid with done_o only
    output logic      [RES_W-1:0] approx_o     // Live approximation register
);
    int         wait_cnt;
    logic       busy;
    logic [3:0] chan;

    // The result carries the channel so the bench can tell which input filled a slot.
    // Outside the done pulse the result toggles so a late sample never looks right.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            busy     <= 1'b0;
            done_o   <= 1'b0;
            result_o <= '1;
            approx_o <= '0;
            wait_cnt <= 0;
            chan     <= 4'h0;
        end
        else
        begin
            done_o   <= 1'b0;
            result_o <= ~result_o;
            if (load_i)
                approx_o <= load_data_i;
            if (req_i)
            begin
                busy     <= 1'b1;
                chan     <= chan_i;
                wait_cnt <= slow_i ? 9 : 1;
            end
            else if (busy && wait_cnt == 0)
            begin
                busy     <= 1'b0;
                done_o   <= 1'b1;
                result_o <= RES_W'({chan, 6'h15});
            end
            else if (busy)
                wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// *** adc_sequence_status_logic_bench.sv ***
// Self-checking bench for the converter sequencing and status logic.
`timescale 1ns/1ns
module adc_sequence_status_logic_bench;
    import adc_seq_pkg::*;
    logic        ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, special = 0, slow = 0;
    logic [7:0]  paddr = 8'h00, pins = 8'h5a;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic        pready, pslverr, rd_err, conv_req, conv_done, approx_load, power_en, irq;
    logic [3:0]  conv_chan;
    logic [9:0]  conv_result, approx_bits, approx_data;
    logic [4:0]  test_ctrl;
    int          num_errors = 0, tests_run = 0;

    always #5 ref_clk = ~ref_clk;

    adc_sequence_status_logic dut_u (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .special_mode_i(special), .port_pin_inputs_i(pins),
        .conv_req_o(conv_req), .conv_chan_o(conv_chan), .conv_done_i(conv_done),
        .conv_result_i(conv_result), .approx_bits_i(approx_bits), .approx_load_o(approx_load),
        .approx_data_o(approx_data), .test_ctrl_o(test_ctrl), .power_en_o(power_en), .irq_o(irq));

    adc_core_model core_u (.clk_i(ref_clk), .reset_n_i(reset_n), .req_i(conv_req), .chan_i(conv_chan),
        .slow_i(slow), .load_i(approx_load), .load_data_i(approx_data), .done_o(conv_done),
        .result_o(conv_result), .approx_o(approx_bits));

    task end_sim;
    begin
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
    begin
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        rd_data = prdata;
        rd_err  = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
        if (n == 20)
        begin
            num_errors++;
            end_sim;
        end
    end
    endtask

    function automatic logic [31:0] exp_res(input logic [3:0] ch);
        return {16'h0000, ch, 6'h15, 6'h00};
    endfunction

    task run_seq(input logic [31:0] ctl);
        int n;
    begin
        apb(1'b1, OFS_START, ctl);
        for (n = 0; n < 100; n++)
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd_data[STAT_SEQ] === 1'b1)
                break;
        end
        if (n == 100)
        begin
            num_errors++;
            end_sim;
        end
    end
    endtask

    task t_multi;
    begin
        apb(1'b1, OFS_POWER, 32'h1);
        check(32'(power_en), 32'h1);
        run_seq(32'h14);
        check(rd_data[7:0], 8'h0f);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, OFS_RESULT + 8'(i * 4), 32'h0);
            check(rd_data, exp_res(4'(4 + i)));
        end
        slow <= 1'b1;
        run_seq(32'h58);
        check(rd_data[10:0], 11'h0ff);
        for (int i = 4; i < 8; i++)
        begin
            apb(1'b0, OFS_RESULT + 8'(i * 4), 32'h0);
            check(rd_data, exp_res(4'(8 + i)));
        end
        apb(1'b1, OFS_START, 32'h58);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data & 32'h80ff, 32'h0);
        $display("multichannel test done");
    end
    endtask

    task t_single;
        int n;
    begin
        slow <= 1'b0;
        apb(1'b1, OFS_IRQ_MSK, 32'h1);
        apb(1'b1, OFS_START, 32'h06);
        apb(1'b1, OFS_IRQ_ST, 32'h3);
        for (n = 0; n < 500 && irq !== 1'b1; n++)
            @(posedge ref_clk);
        check(32'(irq), 32'h1);
        apb(1'b0, OFS_RESULT, 32'h0);
        check(rd_data, exp_res(4'h6));
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data[7:0], 8'h0f);
        apb(1'b0, OFS_RESULT, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data[7:0], 8'h0e);
        apb(1'b0, OFS_RESULT + 8'h0c, 32'h0);
        check(rd_data, exp_res(4'h6));
        apb(1'b1, OFS_IRQ_MSK, 32'h0);
        @(posedge ref_clk);
        check(32'(irq), 32'h0);
        apb(1'b1, OFS_IRQ_MSK, 32'h1);
        apb(1'b1, OFS_IRQ_ST, 32'h1);
        @(posedge ref_clk);
        check(32'(irq), 32'h0);
        $display("single channel and interrupt test done");
    end
    endtask

    task t_fast;
    begin
        apb(1'b1, OFS_POWER, 32'h3);
        run_seq(32'h00);
        apb(1'b0, OFS_RESULT + 8'h08, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data[STAT_SEQ], 1'b0);
        check(rd_data[7:0], 8'h0b);
        $display("fast clear test done");
    end
    endtask

    // Continuous single-channel run: the flag must not come back, the slots keep refilling.
    task t_repeat;
    begin
        apb(1'b1, OFS_POWER, 32'h1);
        run_seq(32'h21);
        special <= 1'b1;
        apb(1'b1, OFS_STATUS, 32'h0);
        special <= 1'b0;
        repeat (60) @(posedge ref_clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data[STAT_SEQ], 1'b0);
        check(rd_data[7:0], 8'h0f);
        apb(1'b0, OFS_RESULT + 8'h04, 32'h0);
        check(rd_data, exp_res(4'h1));
        apb(1'b1, OFS_POWER, 32'h0);
        apb(1'b1, OFS_POWER, 32'h1);
        $display("continuous sequence test done");
    end
    endtask

    task t_test_port;
        logic [31:0] keep;
    begin
        apb(1'b1, OFS_TEST, 32'hffff);
        apb(1'b0, OFS_TEST, 32'h0);
        check(rd_data, 32'h0);
        check(32'(test_ctrl), 32'h0);
        special <= 1'b1;
        apb(1'b1, OFS_TEST, 32'haaa5);
        check(32'(test_ctrl), 32'h1a);
        apb(1'b0, OFS_TEST, 32'h0);
        check(rd_data, 32'haaa5);
        apb(1'b1, OFS_STATUS, 32'h8000);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data[STAT_SEQ], 1'b1);
        apb(1'b1, OFS_TEST, 32'h0400);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data, 32'h0);
        check({27'h0, power_en, test_ctrl}, 32'h20);
        special <= 1'b0;
        apb(1'b1, OFS_STATUS, 32'h80ff);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd_data, 32'h0);
        apb(1'b0, OFS_RESULT, 32'h0);
        keep = rd_data;
        apb(1'b1, OFS_RESULT, 32'hffff);
        apb(1'b0, OFS_RESULT, 32'h0);
        check(rd_data, keep);
        apb(1'b1, OFS_PORT, 32'h0);
        apb(1'b0, OFS_PORT, 32'h0);
        check(rd_data, 32'h5a);
        pins <= 8'ha5;
        apb(1'b0, OFS_PORT, 32'h0);
        check(rd_data, 32'ha5);
        apb(1'b0, 8'hfc, 32'h0);
        check(32'(rd_err), 32'h1);
        $display("test register and port test done");
    end
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_multi;
        t_single;
        t_fast;
        t_repeat;
        t_test_port;
        end_sim;
    end
endmodule
